// *** power_mode_control.sv ***
// Purpose: Power mode controller with idle, stop and suspend over APB
// Assumes: pclk stays alive in every mode; gating outputs act on the clocks
// Notes: Entry waits for instr_done after the selecting write
//
// Contract
// - Idle bit write halts processor once the writing instruction completes.
// - Idle keeps state; only processor clock stops, peripherals keep clocks.
// - Enabled interrupt in idle clears idle and resumes processor.
// - Reset ending any mode runs normal reset sequence from reset vector.
// - Watchdog expiry in idle raises internal reset ending idle.
// - Stop bit halts oscillator, processor and digital peripherals after instruction.
// - Analog peripherals keep their selected states during stop.
// - Only reset ends stop; interrupts never wake it.
// - Missing clock detector stays active in stop and resets when enabled.
// - Regulator off in stop allows only external reset to end stop.
// - Suspend bit halts the high-frequency oscillator; processor may keep running.
// - Suspend ends on either wake pin edge or any reset.
// - Leaving suspend resumes next instruction and services enabled wake interrupt.
// - Bits 7:2 of power mode select are plain flags, reset zero.
// - Stop and idle select bits always read zero.
// - Regulator control bit 3 selects regulator off in stop, reset zero.
//
// Our own choice: the APB slave port.
`include "power_mode_control_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module power_mode_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire logic watchdog_timer_expired,
  input wire logic missing_clock_detector_en,
  input wire logic missing_clock_detector_expired,
  input wire logic wake_interrupt_pin,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic hf_osc_en,
  output logic core_regulator_off,
  output logic internal_reset_req,
  output logic cpu_resume,
  output logic wake_irq,
  output logic [1:0] mode
);

  power_mode_control_pkg::power_mode_t mode_reg;
  power_mode_control_pkg::power_mode_t mode_next;
  logic [5:0] general_flags_reg;
  logic regulator_off_in_stop_reg;
  logic wake_irq_en_reg;
  logic idle_req_reg;
  logic stop_req_reg;
  logic suspend_req_reg;
  logic wake_meta_reg;
  logic wake_sync_reg;
  logic wake_last_reg;
  logic wake_edge;
  logic int_reset;
  logic wr_en;
  logic rd_en;
  logic hit_pms;
  logic hit_reg;
  logic hit_osc;
  logic [7:0] rd_byte;

  assign hit_pms = paddr == `PMC_ADDR_POWER_MODE_SELECT;
  assign hit_reg = paddr == `PMC_ADDR_REGULATOR_CONTROL;
  assign hit_osc = paddr == `PMC_ADDR_OSCILLATOR_CONTROL;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_pms || hit_reg || hit_osc);

  // Wake pin synchroniser on the always-running clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
      wake_last_reg <= 1'b0;
    end else begin
      wake_meta_reg <= wake_interrupt_pin;
      wake_sync_reg <= wake_meta_reg;
      wake_last_reg <= wake_sync_reg;
    end
  end

  // Either edge counts
  assign wake_edge = wake_sync_reg ^ wake_last_reg;

  // Internal reset sources, blocked when the regulator is off in stop
  always_comb begin
    int_reset = 1'b0;
    unique case (mode_reg)
      power_mode_control_pkg::MODE_IDLE: begin
        int_reset = watchdog_timer_expired;
      end
      power_mode_control_pkg::MODE_STOP: begin
        int_reset = !regulator_off_in_stop_reg &&
          missing_clock_detector_en && missing_clock_detector_expired;
      end
      power_mode_control_pkg::MODE_RUN,
      power_mode_control_pkg::MODE_SUSPEND: begin
        int_reset = watchdog_timer_expired ||
          (missing_clock_detector_en && missing_clock_detector_expired);
      end
    endcase
  end

  // Mode selection
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      power_mode_control_pkg::MODE_RUN: begin
        if (instr_done && stop_req_reg) begin
          mode_next = power_mode_control_pkg::MODE_STOP;
        end else if (instr_done && idle_req_reg) begin
          mode_next = power_mode_control_pkg::MODE_IDLE;
        end else if (instr_done && suspend_req_reg) begin
          mode_next = power_mode_control_pkg::MODE_SUSPEND;
        end
      end
      power_mode_control_pkg::MODE_IDLE: begin
        if (irq_pending) begin
          mode_next = power_mode_control_pkg::MODE_RUN;
        end
      end
      power_mode_control_pkg::MODE_STOP: begin
        mode_next = power_mode_control_pkg::MODE_STOP;
      end
      power_mode_control_pkg::MODE_SUSPEND: begin
        if (wake_edge) begin
          mode_next = power_mode_control_pkg::MODE_RUN;
        end
      end
    endcase
    if (int_reset) begin
      mode_next = power_mode_control_pkg::MODE_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= power_mode_control_pkg::MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Mode requests held until the selecting instruction completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
      suspend_req_reg <= 1'b0;
    end else if (int_reset || mode_reg != power_mode_control_pkg::MODE_RUN) begin
      idle_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
      suspend_req_reg <= 1'b0;
    end else if (wr_en && hit_pms) begin
      idle_req_reg <= idle_req_reg || pwdata[`PMC_IDLE_BIT];
      stop_req_reg <= stop_req_reg || pwdata[`PMC_STOP_BIT];
    end else if (wr_en && hit_osc) begin
      suspend_req_reg <= suspend_req_reg || pwdata[`PMC_SUSPEND_BIT];
    end else if (instr_done) begin
      idle_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
      suspend_req_reg <= 1'b0;
    end
  end

  // Software flags and configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_flags_reg <= `PMC_FLAGS_RESET;
      regulator_off_in_stop_reg <= 1'(`PMC_REG_CTRL_RESET >> `PMC_STOP_REG_OFF_BIT);
      wake_irq_en_reg <= 1'(`PMC_OSC_CTRL_RESET >> `PMC_WAKE_IRQ_EN_BIT);
    end else if (wr_en) begin
      if (hit_pms) begin
        general_flags_reg <= pwdata[`PMC_FLAGS_MSB:`PMC_FLAGS_LSB];
      end
      if (hit_reg) begin
        regulator_off_in_stop_reg <= pwdata[`PMC_STOP_REG_OFF_BIT];
      end
      if (hit_osc) begin
        wake_irq_en_reg <= pwdata[`PMC_WAKE_IRQ_EN_BIT];
      end
    end
  end

  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    if (hit_pms) begin
      rd_byte[`PMC_FLAGS_MSB:`PMC_FLAGS_LSB] = general_flags_reg;
    end else if (hit_reg) begin
      rd_byte[`PMC_STOP_REG_OFF_BIT] = regulator_off_in_stop_reg;
      rd_byte[`PMC_WAKE_STATUS_BIT] = wake_sync_reg;
    end else if (hit_osc) begin
      rd_byte[`PMC_SUSPEND_BIT] = mode_reg == power_mode_control_pkg::MODE_SUSPEND;
      rd_byte[`PMC_WAKE_IRQ_EN_BIT] = wake_irq_en_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // Gating and event outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      hf_osc_en <= 1'b1;
      core_regulator_off <= 1'b0;
      internal_reset_req <= 1'b0;
      cpu_resume <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      // Only the processor clock stops in idle
      cpu_clk_en <= mode_next != power_mode_control_pkg::MODE_IDLE &&
        mode_next != power_mode_control_pkg::MODE_STOP;
      // Analog enables are not touched here
      periph_clk_en <= mode_next != power_mode_control_pkg::MODE_STOP;
      hf_osc_en <= mode_next != power_mode_control_pkg::MODE_STOP &&
        mode_next != power_mode_control_pkg::MODE_SUSPEND;
      core_regulator_off <= mode_next == power_mode_control_pkg::MODE_STOP &&
        regulator_off_in_stop_reg;
      internal_reset_req <= int_reset;
      cpu_resume <= mode_reg == power_mode_control_pkg::MODE_IDLE && irq_pending && !int_reset;
      wake_irq <= mode_reg == power_mode_control_pkg::MODE_SUSPEND && wake_edge &&
        wake_irq_en_reg && !int_reset;
    end
  end

  assign mode = mode_reg;

  // Checks
  sequence s_idle_entry;
    mode_reg == power_mode_control_pkg::MODE_RUN && idle_req_reg && !stop_req_reg && instr_done;
  endsequence

  sequence s_idle_irq;
    mode_reg == power_mode_control_pkg::MODE_IDLE && irq_pending && !int_reset;
  endsequence

  property p_idle_entry;
    @(posedge pclk) disable iff (!presetn)
      (s_idle_entry and !int_reset) |=> mode_reg == power_mode_control_pkg::MODE_IDLE ##0 !cpu_clk_en;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

  property p_idle_periph;
    @(posedge pclk) disable iff (!presetn)
      mode_reg == power_mode_control_pkg::MODE_IDLE |=> periph_clk_en && hf_osc_en;
  endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("peripheral clock lost in idle");

  property p_idle_wake;
    @(posedge pclk) disable iff (!presetn)
      s_idle_irq |=> mode_reg == power_mode_control_pkg::MODE_RUN && cpu_resume && cpu_clk_en;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not left on interrupt");

  property p_wdt_idle;
    @(posedge pclk) disable iff (!presetn)
      mode_reg == power_mode_control_pkg::MODE_IDLE && watchdog_timer_expired
      |=> internal_reset_req && mode_reg == power_mode_control_pkg::MODE_RUN;
  endproperty
  a_wdt_idle: assert property (p_wdt_idle) else $error("watchdog did not end idle");

  property p_stop_hold;
    @(posedge pclk) disable iff (!presetn)
      mode_reg == power_mode_control_pkg::MODE_STOP && !int_reset
      |=> mode_reg == power_mode_control_pkg::MODE_STOP && !cpu_clk_en && !hf_osc_en && !periph_clk_en;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");

  property p_mcd_stop;
    @(posedge pclk) disable iff (!presetn)
      mode_reg == power_mode_control_pkg::MODE_STOP && !regulator_off_in_stop_reg &&
      missing_clock_detector_en && missing_clock_detector_expired |=> internal_reset_req;
  endproperty
  a_mcd_stop: assert property (p_mcd_stop) else $error("detector reset missed in stop");

  property p_reg_off;
    @(posedge pclk) disable iff (!presetn)
      mode_reg == power_mode_control_pkg::MODE_STOP && regulator_off_in_stop_reg
      |=> !internal_reset_req && core_regulator_off;
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulator-off stop misbehaved");

  property p_suspend_wake;
    @(posedge pclk) disable iff (!presetn)
      mode_reg == power_mode_control_pkg::MODE_SUSPEND && $changed(wake_sync_reg)
      |=> mode_reg == power_mode_control_pkg::MODE_RUN ##1 hf_osc_en;
  endproperty
  a_suspend_wake: assert property (p_suspend_wake) else $error("suspend not left on edge");

  property p_suspend_cpu;
    @(posedge pclk) disable iff (!presetn)
      mode_reg == power_mode_control_pkg::MODE_SUSPEND |-> ##1 cpu_clk_en;
  endproperty
  a_suspend_cpu: assert property (p_suspend_cpu) else $error("processor halted in suspend");

  property p_read_zero;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && hit_pms |=> prdata[1:0] == 2'b00 ##0 prdata[7:2] == general_flags_reg;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("select bits read nonzero");

  property p_int_reset_exit;
    @(posedge pclk) disable iff (!presetn)
      int_reset |=> mode_reg == power_mode_control_pkg::MODE_RUN && internal_reset_req;
  endproperty
  a_int_reset_exit: assert property (p_int_reset_exit) else $error("internal reset did not end mode");

  property p_suspend_hold;
    @(posedge pclk) disable iff (!presetn)
      mode_reg == power_mode_control_pkg::MODE_SUSPEND && !wake_edge && !int_reset
      |=> mode_reg == power_mode_control_pkg::MODE_SUSPEND && !hf_osc_en && cpu_clk_en;
  endproperty
  a_suspend_hold: assert property (p_suspend_hold) else $error("suspend not held");

  property p_wake_irq;
    @(posedge pclk) disable iff (!presetn)
      mode_reg == power_mode_control_pkg::MODE_SUSPEND && wake_edge && wake_irq_en_reg && !int_reset
      |=> wake_irq && mode_reg == power_mode_control_pkg::MODE_RUN;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake interrupt missing");

endmodule

`default_nettype wire

// *** power_mode_control_bench.sv ***
// Purpose: Self-checking bench for power_mode_control
// Assumes: Zero-wait APB slave, registers in the low byte
// Notes: Inputs change by non-blocking assignment on the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_control_cfg.svh"

module power_mode_control_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic instr_done = 1'b0;
  logic irq_pending = 1'b0;
  logic wdt_exp = 1'b0;
  logic mcd_en = 1'b0;
  logic mcd_exp = 1'b0;
  logic wake_pin = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpu_clk_en;
  logic periph_clk_en;
  logic hf_osc_en;
  logic core_regulator_off;
  logic internal_reset_req;
  logic cpu_resume;
  logic wake_irq;
  logic [1:0] mode;
  logic [31:0] rd;
  logic serr;
  int fails = 0;
  int n_checks = 0;

  always #5 pclk = ~pclk;

  power_mode_control u_power_mode_control (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_done(instr_done), .irq_pending(irq_pending), .watchdog_timer_expired(wdt_exp),
    .missing_clock_detector_en(mcd_en), .missing_clock_detector_expired(mcd_exp),
    .wake_interrupt_pin(wake_pin), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .hf_osc_en(hf_osc_en), .core_regulator_off(core_regulator_off), .internal_reset_req(internal_reset_req),
    .cpu_resume(cpu_resume), .wake_irq(wake_irq), .mode(mode));

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ck_mode(input logic [1:0] e);
    n_checks++;
    if (mode !== e) begin
      fails++;
      $display("MISMATCH mode expected %h seen %h", e, mode);
    end
  endtask

  task automatic ck_en(input logic c, input logic p, input logic h);
    ck("cpu_clk_en", 32'(c), 32'(cpu_clk_en));
    ck("periph_clk_en", 32'(p), 32'(periph_clk_en));
    ck("hf_osc_en", 32'(h), 32'(hf_osc_en));
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 8) begin
      fails++;
      end_of_test();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_ck(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    ck("prdata", e, rd);
  endtask

  // One-cycle pulse: 0 instruction done, 1 interrupt, 2 watchdog, 3 detector
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: instr_done <= 1'b1;
      1: irq_pending <= 1'b1;
      2: wdt_exp <= 1'b1;
      default: mcd_exp <= 1'b1;
    endcase
    @(posedge pclk);
    instr_done <= 1'b0;
    irq_pending <= 1'b0;
    wdt_exp <= 1'b0;
    mcd_exp <= 1'b0;
    #1;
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
  endtask

  task automatic wait_wake(input logic exp_irq);
    int i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      #1;
      seen = seen | wake_irq;
      if (mode === power_mode_control_pkg::MODE_RUN) break;
    end
    if (i == 8) begin
      fails++;
      end_of_test();
    end
    ck("wake_irq", 32'(exp_irq), 32'(seen));
  endtask

  task automatic t_reset_values();
    ck_mode(power_mode_control_pkg::MODE_RUN);
    ck_en(1'b1, 1'b1, 1'b1);
    ck("core_regulator_off", 32'h0, 32'(core_regulator_off));
    rd_ck(`PMC_ADDR_POWER_MODE_SELECT, 32'h0000_0000);
    rd_ck(`PMC_ADDR_REGULATOR_CONTROL, 32'h0000_0000);
    rd_ck(`PMC_ADDR_OSCILLATOR_CONTROL, 32'h0000_0000);
  endtask

  task automatic t_idle();
    apb(1'b1, `PMC_ADDR_POWER_MODE_SELECT, 32'h0000_00a9);
    rd_ck(`PMC_ADDR_POWER_MODE_SELECT, 32'h0000_00a8);
    pulse(1);
    ck_mode(power_mode_control_pkg::MODE_RUN);
    pulse(0);
    ck_mode(power_mode_control_pkg::MODE_IDLE);
    ck_en(1'b0, 1'b1, 1'b1);
    rd_ck(`PMC_ADDR_POWER_MODE_SELECT, 32'h0000_00a8);
    pulse(1);
    ck_mode(power_mode_control_pkg::MODE_RUN);
    ck("cpu_resume", 32'h1, 32'(cpu_resume));
    ck_en(1'b1, 1'b1, 1'b1);
  endtask

  task automatic t_idle_watchdog();
    apb(1'b1, `PMC_ADDR_POWER_MODE_SELECT, 32'h0000_00fd);
    pulse(0);
    ck_mode(power_mode_control_pkg::MODE_IDLE);
    pulse(2);
    ck("internal_reset_req", 32'h1, 32'(internal_reset_req));
    do_reset();
    ck_mode(power_mode_control_pkg::MODE_RUN);
    rd_ck(`PMC_ADDR_POWER_MODE_SELECT, 32'h0000_0000);
  endtask

  task automatic t_stop(input logic reg_off);
    apb(1'b1, `PMC_ADDR_REGULATOR_CONTROL, {28'h0, reg_off, 3'h0});
    rd_ck(`PMC_ADDR_REGULATOR_CONTROL, {28'h0, reg_off, 3'h0});
    apb(1'b1, `PMC_ADDR_POWER_MODE_SELECT, 32'h0000_0002);
    rd_ck(`PMC_ADDR_POWER_MODE_SELECT, 32'h0000_0000);
    pulse(0);
    ck_mode(power_mode_control_pkg::MODE_STOP);
    ck_en(1'b0, 1'b0, 1'b0);
    ck("core_regulator_off", 32'(reg_off), 32'(core_regulator_off));
    pulse(1);
    ck_mode(power_mode_control_pkg::MODE_STOP);
    @(posedge pclk);
    mcd_en <= 1'b1;
    pulse(3);
    ck("internal_reset_req", 32'(!reg_off), 32'(internal_reset_req));
    ck_mode(reg_off ? power_mode_control_pkg::MODE_STOP : power_mode_control_pkg::MODE_RUN);
    ck("core_regulator_off", 32'(reg_off), 32'(core_regulator_off));
    do_reset();
    ck_mode(power_mode_control_pkg::MODE_RUN);
    ck("core_regulator_off", 32'h0, 32'(core_regulator_off));
    rd_ck(`PMC_ADDR_REGULATOR_CONTROL, 32'h0000_0000);
  endtask

  task automatic t_suspend(input logic irq_en);
    apb(1'b1, `PMC_ADDR_OSCILLATOR_CONTROL, {26'h0, 1'b1, 4'h0, irq_en});
    pulse(0);
    ck_mode(power_mode_control_pkg::MODE_SUSPEND);
    ck_en(1'b1, 1'b1, 1'b0);
    rd_ck(`PMC_ADDR_OSCILLATOR_CONTROL, {26'h0, 1'b1, 4'h0, irq_en});
    @(posedge pclk);
    wake_pin <= ~wake_pin;
    wait_wake(irq_en);
    ck_mode(power_mode_control_pkg::MODE_RUN);
    ck("hf_osc_en", 32'h1, 32'(hf_osc_en));
    rd_ck(`PMC_ADDR_REGULATOR_CONTROL, {24'h0, 1'b0, wake_pin, 6'h0});
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'h000, 32'h0000_00ff);
    ck("pslverr", 32'h1, 32'(serr));
    rd_ck(12'h000, 32'h0000_0000);
    ck("pslverr", 32'h1, 32'(serr));
    rd_ck(`PMC_ADDR_POWER_MODE_SELECT, 32'h0000_0000);
    ck("pslverr", 32'h0, 32'(serr));
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset_values();
    t_idle();
    t_idle_watchdog();
    t_stop(1'b0);
    mcd_en <= 1'b0;
    t_stop(1'b1);
    t_suspend(1'b1);
    t_suspend(1'b0);
    t_unmapped();
    end_of_test();
  end
endmodule
`default_nettype wire

// *** power_mode_control_cfg.svh ***
// Purpose: Offsets, field positions, reset values for power_mode_control
// Assumes: Register index times four gives the APB byte address
// Notes: Definitions only
`ifndef POWER_MODE_CONTROL_CFG_SVH
`define POWER_MODE_CONTROL_CFG_SVH
`define PMC_IDX_POWER_MODE_SELECT 8'h87
`define PMC_IDX_REGULATOR_CONTROL 8'hc9
`define PMC_IDX_OSCILLATOR_CONTROL 8'hb2
`define PMC_ADDR_POWER_MODE_SELECT 12'h21c
`define PMC_ADDR_REGULATOR_CONTROL 12'h324
`define PMC_ADDR_OSCILLATOR_CONTROL 12'h2c8
`define PMC_IDLE_BIT 0
`define PMC_STOP_BIT 1
`define PMC_FLAGS_LSB 2
`define PMC_FLAGS_MSB 7
`define PMC_SUSPEND_BIT 5
`define PMC_WAKE_IRQ_EN_BIT 0
`define PMC_STOP_REG_OFF_BIT 3
`define PMC_WAKE_STATUS_BIT 6
`define PMC_FLAGS_RESET 6'h00
`define PMC_REG_CTRL_RESET 8'h00
`define PMC_OSC_CTRL_RESET 8'h00
`endif

// *** power_mode_control_pkg.sv ***
// Purpose: Types for power_mode_control
// Assumes: Constants live in power_mode_control_cfg.svh
// Notes: Gray codes along run, idle, stop and run, suspend
package power_mode_control_pkg;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_STOP = 2'b11,
    MODE_SUSPEND = 2'b10
  } power_mode_t;
endpackage
